/* File: core/rcfg_consts.svh */
// Constants for the reset and configuration word block.
// Assumes inclusion by bare name from core/ files.
`ifndef RCFG_CONSTS_SVH
`define RCFG_CONSTS_SVH

// ==========================================================
// Configuration word location and fields
`define CFG_WORD_ADDR 14'h2007
`define CFG_SPACE_LO 14'h2000
`define CFG_SPACE_HI 14'h3FFF
`define CFG_WIDTH 14
`define CFG_RESET 14'h3FFF
`define CFG_FSCM_BIT 11
`define CFG_SWITCH_BIT 10
`define CFG_BOR_HI 9
`define CFG_BOR_LO 8
`define CFG_DPROT_BIT 7
`define CFG_PPROT_BIT 6
`define CFG_PINFN_BIT 5
`define CFG_PUT_DIS_BIT 4
`define CFG_WDT_BIT 3
`define CFG_OSC_HI 2
`define CFG_OSC_LO 0

// ==========================================================
// Timing
`define CLK_HZ 100000000
`define LFOSC_HZ 31000
`define LFOSC_DIV (`CLK_HZ / `LFOSC_HZ)
`define PUT_MS 64
`define PUT_TICKS ((`PUT_MS * `LFOSC_HZ) / 1000)
`define OST_TICKS 1024
`define PIN_FILTER_NS 2000
`define CLK_NS 10
`define PIN_FILTER_CYC (`PIN_FILTER_NS / `CLK_NS)

`endif

/* File: core/rcfg_pkg.sv */
// Types for the reset and configuration word block.
// Assumes the constants header sits beside it.
`include "rcfg_consts.svh"
package rcfg_pkg;
  typedef enum logic [2:0] {
    OSC_LP, OSC_XT, OSC_HS, OSC_EC, OSC_INT_IO, OSC_INT_CLKOUT, OSC_RC_IO, OSC_RC_CLKOUT
  } osc_mode_t;
  typedef enum logic [1:0] {
    BOR_OFF, BOR_SOFTWARE, BOR_RUN_ONLY, BOR_ALWAYS
  } bor_mode_t;
  typedef struct packed {
    logic fail_safe_monitor_enable;
    logic int_ext_switchover_enable;
    bor_mode_t brownout_mode_select;
    logic data_memory_protect;
    logic program_memory_protect;
    logic reset_pin_function_select;
    logic powerup_timer_enable;
    logic watchdog_enable;
    osc_mode_t clock_source_select;
  } cfg_opts_t;
  typedef struct packed {
    logic power_on_n;
    logic brownout_n;
    logic timeout_status_flag;
    logic powerdown_status_flag;
  } reset_status_t;
endpackage

/* File: core/rcfg_pin_filter.sv */
// Glitch filter for the master clear pin.
// Assumes an input that is asynchronous to I_CLK.
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_consts.svh"
module rcfg_pin_filter (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level
);
  // ========================================================
  // Three-stage synchroniser and width filter
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic level_q;
  logic level_d;

  always_comb begin
    sync_d = {sync_q[1:0], i_pin};
    cnt_d = cnt_q;
    level_d = level_q;
    if (sync_q[2] != sync_q[1] || sync_q[2] == level_q) begin
      cnt_d = 16'h0000;
    end else if (cnt_q == 16'(`PIN_FILTER_CYC - 1)) begin
      // Only a pulse that stays for the whole window is accepted
      level_d = sync_q[2];
      cnt_d = 16'h0000;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync_q <= 3'h7;
      cnt_q <= 16'h0000;
      level_q <= 1'b1;
    end else begin
      sync_q <= sync_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;
endmodule
`default_nettype wire

/* File: core/rcfg_reset_ctrl.sv */
// Reset sequencer and configuration word decoder.
// Assumes analog detectors supply power-on and brown-out levels on I_CLK.
// How it works
// - Programmed config bits read zero, unprogrammed read one; decode uses read values.
// - Config word sits at 2007h, reachable only in programming mode.
// - Bit 11 high enables fail-safe clock monitor.
// - Bit 10 high enables internal/external clock switchover.
// - Bits 9-8 pick brown-out mode: always, run only, software, off.
// - Bit 7 low protects data memory; releasing it erases data memory.
// - Bit 6 low protects program memory; releasing it erases program memory.
// - Bit 5 high makes pin a reset input; low makes it plain input.
// - Reset pin function turns on weak pull-up.
// - Bit 3 high enables the watchdog.
// - Bits 2-0 select one of eight clock modes.
// - Brown-out enable does not enable the power-up timer.
// - Status tells power-on, watchdog run/sleep, pin run/sleep, brown-out apart.
// - Most registers reset on all resets except watchdog wake-up.
// - Some registers never reset; a separate output marks power-on only.
// - Pin reset path filters away short low glitches.
// - Watchdog reset never drives the reset pin low.
// - Pin reset in internal or RC mode stops the internal oscillator.
// - Power-up timer holds reset 64 ms after power-on or brown-out.
// - Start-up timer holds reset until crystal is stable.
// - Sleep ends on pin reset, watchdog wake-up or interrupt.
// - Power-up timer counts low-frequency internal oscillator ticks.
// - Power-up timer runs after power-on, then start-up timer.
// - Power-on flag cleared by power-on only; software sets it.
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_consts.svh"
module rcfg_reset_ctrl #(
  parameter int PUT_TICKS = `PUT_TICKS,
  parameter int OST_TICKS = `OST_TICKS,
  parameter int LFOSC_DIV = `LFOSC_DIV
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic i_power_on,
  input wire logic i_brownout_low,
  input wire logic i_master_clear_pin,
  input wire logic i_prog_mode,
  input wire logic i_prog_wr,
  input wire logic [13:0] i_prog_addr,
  input wire logic [13:0] i_prog_wdata,
  output logic [13:0] o_prog_rdata,
  input wire logic i_sleeping,
  input wire logic i_watchdog_timeout,
  input wire logic i_interrupt,
  input wire logic i_software_brownout_enable,
  input wire logic i_power_on_flag_set,
  input wire logic i_brownout_flag_set,
  input wire logic i_clear_timeout_powerdown,
  input wire logic i_enter_sleep,
  output rcfg_pkg::cfg_opts_t o_cfg,
  output rcfg_pkg::reset_status_t o_status,
  output logic o_core_reset,
  output logic o_power_on_reset,
  output logic o_wake,
  output logic o_int_osc_stop,
  output logic o_pin_pullup_en,
  output logic o_pin_digital_in,
  output logic o_erase_data_mem,
  output logic o_erase_prog_mem
);
  // ==========================================================
  // Configuration word storage
  logic [13:0] cfg_q;
  logic [13:0] cfg_d;
  logic erase_d_q;
  logic erase_d_d;
  logic erase_p_q;
  logic erase_p_d;
  logic cfg_hit;

  function automatic rcfg_pkg::cfg_opts_t decode_cfg(input logic [13:0] w);
    rcfg_pkg::cfg_opts_t o;
    o.fail_safe_monitor_enable = w[`CFG_FSCM_BIT];
    o.int_ext_switchover_enable = w[`CFG_SWITCH_BIT];
    o.brownout_mode_select = rcfg_pkg::bor_mode_t'(w[`CFG_BOR_HI:`CFG_BOR_LO]);
    o.data_memory_protect = ~w[`CFG_DPROT_BIT];
    o.program_memory_protect = ~w[`CFG_PPROT_BIT];
    o.reset_pin_function_select = w[`CFG_PINFN_BIT];
    o.powerup_timer_enable = ~w[`CFG_PUT_DIS_BIT];
    o.watchdog_enable = w[`CFG_WDT_BIT];
    o.clock_source_select = rcfg_pkg::osc_mode_t'(w[`CFG_OSC_HI:`CFG_OSC_LO]);
    return o;
  endfunction

  // Programming writes the whole word, setting or clearing bits; erased state reads one
  assign cfg_hit = i_prog_mode && (i_prog_addr == `CFG_WORD_ADDR);

  always_comb begin
    cfg_d = cfg_q;
    erase_d_d = 1'b0;
    erase_p_d = 1'b0;
    if (cfg_hit && i_prog_wr) begin
      cfg_d = i_prog_wdata;
      // Lifting protection wipes the guarded memory
      erase_d_d = ~cfg_q[`CFG_DPROT_BIT] & i_prog_wdata[`CFG_DPROT_BIT];
      erase_p_d = ~cfg_q[`CFG_PPROT_BIT] & i_prog_wdata[`CFG_PPROT_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      cfg_q <= `CFG_RESET;
      erase_d_q <= 1'b0;
      erase_p_q <= 1'b0;
      o_prog_rdata <= 14'h0000;
    end else begin
      cfg_q <= cfg_d;
      erase_d_q <= erase_d_d;
      erase_p_q <= erase_p_d;
      o_prog_rdata <= cfg_hit ? cfg_q : 14'h0000;
    end
  end

  rcfg_pkg::cfg_opts_t cfg;
  assign cfg = decode_cfg(cfg_q);
  assign o_cfg = cfg;
  assign o_erase_data_mem = erase_d_q;
  assign o_erase_prog_mem = erase_p_q;

  // ==========================================================
  // Pin path, sync of detector levels
  logic pin_level;
  logic pin_reset;
  logic pwr_s1_q;
  logic pwr_s2_q;
  logic pwr_s3_q;
  logic bor_s1_q;
  logic bor_s2_q;
  logic bor_s3_q;
  logic pwr_on;
  logic bor_low;

  rcfg_pin_filter u_filter (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_pin(i_master_clear_pin),
    .o_level(pin_level)
  );

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      {pwr_s1_q, pwr_s2_q, pwr_s3_q} <= 3'h7;
      {bor_s1_q, bor_s2_q, bor_s3_q} <= 3'h0;
    end else begin
      {pwr_s1_q, pwr_s2_q, pwr_s3_q} <= {i_power_on, pwr_s1_q, pwr_s2_q};
      {bor_s1_q, bor_s2_q, bor_s3_q} <= {i_brownout_low, bor_s1_q, bor_s2_q};
    end
  end

  logic pwr_q;
  logic bor_q;
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      pwr_q <= 1'b1;
      bor_q <= 1'b0;
    end else begin
      if (pwr_s2_q == pwr_s3_q) pwr_q <= pwr_s3_q;
      if (bor_s2_q == bor_s3_q) bor_q <= bor_s3_q;
    end
  end
  assign pwr_on = pwr_q;

  // Pin reset only when pin function selected; otherwise tied inactive
  assign pin_reset = cfg.reset_pin_function_select & ~pin_level;
  assign o_pin_pullup_en = cfg.reset_pin_function_select;
  assign o_pin_digital_in = ~cfg.reset_pin_function_select;

  // Brown-out gating by mode; independent of power-up timer enable
  always_comb begin
    case (cfg.brownout_mode_select)
      rcfg_pkg::BOR_ALWAYS: bor_low = bor_q;
      rcfg_pkg::BOR_RUN_ONLY: bor_low = bor_q & ~i_sleeping;
      rcfg_pkg::BOR_SOFTWARE: bor_low = bor_q & i_software_brownout_enable;
      default: bor_low = 1'b0;
    endcase
  end

  // ==========================================================
  // Low-frequency tick divider
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic lf_tick;
  assign lf_tick = (div_q == 16'(LFOSC_DIV - 1));
  always_comb begin
    div_d = lf_tick ? 16'h0000 : div_q + 16'h0001;
  end

  // ==========================================================
  // Sequencer
  typedef enum {ST_POR, ST_PUT, ST_OST, ST_RUN} seq_t;
  seq_t st_q;
  seq_t st_d;
  logic [15:0] tm_q;
  logic [15:0] tm_d;
  logic crystal;
  logic wdt_reset;
  logic wdt_wake;

  assign crystal = (cfg.clock_source_select == rcfg_pkg::OSC_LP) ||
                   (cfg.clock_source_select == rcfg_pkg::OSC_XT) ||
                   (cfg.clock_source_select == rcfg_pkg::OSC_HS);
  // Watchdog only resets internally, no pin drive exists
  assign wdt_reset = i_watchdog_timeout & cfg.watchdog_enable & ~i_sleeping;
  assign wdt_wake = i_watchdog_timeout & cfg.watchdog_enable & i_sleeping;

  always_comb begin
    st_d = st_q;
    tm_d = tm_q;
    case (st_q)
      ST_POR: begin
        tm_d = 16'h0000;
        if (!pwr_on && !bor_low) begin
          // Timer runs after power-on ends
          st_d = cfg.powerup_timer_enable ? ST_PUT : (crystal ? ST_OST : ST_RUN);
        end
      end
      ST_PUT: begin
        if (lf_tick) tm_d = tm_q + 16'h0001;
        if (tm_q == 16'(PUT_TICKS)) begin
          st_d = crystal ? ST_OST : ST_RUN;
          tm_d = 16'h0000;
        end
      end
      ST_OST: begin
        // Crystal cycles approximated by core clock
        tm_d = tm_q + 16'h0001;
        if (tm_q == 16'(OST_TICKS - 1)) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        tm_d = 16'h0000;
        if (wdt_wake && crystal) begin
          st_d = ST_OST;
        end
      end
    endcase
    if (pwr_on || bor_low) begin
      // Brown-out during power-up timer restarts it
      st_d = ST_POR;
      tm_d = 16'h0000;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      st_q <= ST_POR;
      tm_q <= 16'h0000;
      div_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      tm_q <= tm_d;
      div_q <= div_d;
    end
  end

  // Held while any timer or source active; interrupt wake-up does not reset, crystal-mode watchdog wake reruns start-up timer
  assign o_core_reset = (st_q != ST_RUN) | pin_reset | wdt_reset;
  assign o_power_on_reset = pwr_on;
  assign o_int_osc_stop = pin_reset & ~crystal & (cfg.clock_source_select != rcfg_pkg::OSC_EC);
  assign o_wake = i_sleeping & (pin_reset | wdt_wake | i_interrupt);

  // ==========================================================
  // Reset cause status
  rcfg_pkg::reset_status_t stat_q;
  rcfg_pkg::reset_status_t stat_d;
  always_comb begin
    stat_d = stat_q;
    if (i_power_on_flag_set) stat_d.power_on_n = 1'b1;
    if (i_brownout_flag_set) stat_d.brownout_n = 1'b1;
    if (i_clear_timeout_powerdown) begin
      stat_d.timeout_status_flag = 1'b1;
      stat_d.powerdown_status_flag = 1'b1;
    end
    if (i_enter_sleep) stat_d.powerdown_status_flag = 1'b0;
    // Hardware events win over software writes
    if (pin_reset && i_sleeping) begin
      stat_d.timeout_status_flag = 1'b1;
      stat_d.powerdown_status_flag = 1'b0;
    end
    if (wdt_reset) stat_d.timeout_status_flag = 1'b0;
    if (wdt_wake) begin
      stat_d.timeout_status_flag = 1'b0;
      stat_d.powerdown_status_flag = 1'b0;
    end
    if (bor_low) begin
      stat_d.brownout_n = 1'b0;
      stat_d.timeout_status_flag = 1'b1;
      stat_d.powerdown_status_flag = 1'b1;
    end
    if (pwr_on) begin
      stat_d.power_on_n = 1'b0;
      stat_d.timeout_status_flag = 1'b1;
      stat_d.powerdown_status_flag = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      stat_q <= 4'b0011;
    end else begin
      stat_q <= stat_d;
    end
  end
  assign o_status = stat_q;
endmodule
`default_nettype wire

/* File: verification/rcfg_reset_ctrl_props.sv */
// Port checker for the reset sequencer and configuration decoder.
// Assumes a bind onto rcfg_reset_ctrl that passes the timer parameters.
`timescale 1ns/1ps
`default_nettype none
module rcfg_reset_ctrl_props #(
  parameter int PUT_TICKS = 4,
  parameter int LFOSC_DIV = 2
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic i_power_on,
  input wire logic i_prog_mode,
  input wire logic [13:0] i_prog_addr,
  input wire logic [13:0] o_prog_rdata,
  input wire logic i_sleeping,
  input wire logic i_interrupt,
  input wire rcfg_pkg::cfg_opts_t o_cfg,
  input wire logic o_core_reset,
  input wire logic o_power_on_reset,
  input wire logic o_wake,
  input wire logic o_int_osc_stop,
  input wire logic o_pin_pullup_en,
  input wire logic o_pin_digital_in,
  input wire logic o_erase_data_mem,
  input wire logic o_erase_prog_mem
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // ==========================================================
  // Length of the reset hold that follows a power-on
  int hold_q;
  int hold_d;
  logic seen_q;
  logic seen_d;
  always_comb begin
    hold_d = (o_power_on_reset || !o_core_reset) ? 0 : hold_q + 1;
    seen_d = o_power_on_reset || (seen_q && o_core_reset);
  end
  always_ff @(posedge I_CLK) begin
    hold_q <= I_RESET ? 0 : hold_d;
    seen_q <= I_RESET ? 1'h0 : seen_d;
  end
  // ==========================================================
  // Assertions
  a_pullup_pin_fn: assert property (o_pin_pullup_en == o_cfg.reset_pin_function_select)
    else $error("pull-up does not follow pin function");
  a_digital_pin_fn: assert property (o_pin_digital_in != o_cfg.reset_pin_function_select)
    else $error("digital input does not follow pin function");
  a_rdata_refused: assert property ($past(!i_prog_mode || i_prog_addr != 14'h2007) |-> o_prog_rdata == 14'h0000)
    else $error("config word visible outside programming access");
  a_erase_prog_on: assert property (o_erase_prog_mem == $fell(o_cfg.program_memory_protect))
    else $error("program erase pulse wrong");
  a_erase_data_on: assert property (o_erase_data_mem == $fell(o_cfg.data_memory_protect))
    else $error("data erase pulse wrong");
  a_osc_stop_mode: assert property (o_int_osc_stop |-> o_cfg.clock_source_select[2])
    else $error("oscillator stop outside internal or RC mode");
  a_por_holds_core: assert property (i_power_on [*6] |-> o_core_reset)
    else $error("core not in reset during power-on");
  a_put_hold_len: assert property ($fell(o_core_reset) && seen_q && o_cfg.powerup_timer_enable |-> hold_q >= PUT_TICKS * LFOSC_DIV)
    else $error("power-up hold too short");
  a_sleep_wake_irq: assert property (i_sleeping && i_interrupt |-> o_wake)
    else $error("no wake on interrupt in sleep");
endmodule
`default_nettype wire

/* File: verification/rcfg_pin_driver.sv */
// Model of the board driving the master clear pin.
// Assumes the bench asks for a low level; otherwise the pin is released.
`timescale 1ns/1ps
`default_nettype none
module rcfg_pin_driver (
  input wire logic i_clk,
  input wire logic i_hold_low,
  input wire logic i_pullup_en,
  output logic o_pin
);
  logic float_q;
  always @(posedge i_clk) begin
    float_q <= !float_q;
  end
  initial float_q = 1'h0;
  // Released pin floats unless the device pull-up is on
  assign o_pin = i_hold_low ? 1'h0 : (i_pullup_en ? 1'h1 : float_q);
endmodule
`default_nettype wire

/* File: verification/test_reset_and_config_word_control.sv */
// Self-checking bench for the reset and configuration block.
// Assumes shortened timers; the pin comes from the pin driver model.
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_config_word_control;
  logic I_CLK, I_RESET, i_power_on, pin, hold_low, i_prog_mode, i_prog_wr;
  logic [13:0] i_prog_addr, i_prog_wdata, o_prog_rdata, cur_w;
  logic i_sleeping, i_watchdog_timeout, i_interrupt, i_power_on_flag_set;
  logic i_clear_timeout_powerdown, i_enter_sleep, o_core_reset, o_power_on_reset;
  logic o_wake, o_int_osc_stop, o_pin_pullup_en, o_pin_digital_in, o_erase_data_mem;
  logic o_erase_prog_mem, bor_in, bor_flag_set;
  rcfg_pkg::cfg_opts_t o_cfg;
  rcfg_pkg::reset_status_t o_status;
  int failures, check_count, n;
  rcfg_reset_ctrl #(.PUT_TICKS(4), .OST_TICKS(4), .LFOSC_DIV(2)) dut_u (.I_CLK(I_CLK),
    .I_RESET(I_RESET), .i_power_on(i_power_on), .i_brownout_low(bor_in),
    .i_master_clear_pin(pin), .i_prog_mode(i_prog_mode), .i_prog_wr(i_prog_wr),
    .i_prog_addr(i_prog_addr), .i_prog_wdata(i_prog_wdata), .o_prog_rdata(o_prog_rdata),
    .i_sleeping(i_sleeping), .i_watchdog_timeout(i_watchdog_timeout),
    .i_interrupt(i_interrupt), .i_software_brownout_enable(1'h0),
    .i_power_on_flag_set(i_power_on_flag_set), .i_brownout_flag_set(bor_flag_set),
    .i_clear_timeout_powerdown(i_clear_timeout_powerdown), .i_enter_sleep(i_enter_sleep),
    .o_cfg(o_cfg), .o_status(o_status), .o_core_reset(o_core_reset),
    .o_power_on_reset(o_power_on_reset), .o_wake(o_wake), .o_int_osc_stop(o_int_osc_stop),
    .o_pin_pullup_en(o_pin_pullup_en), .o_pin_digital_in(o_pin_digital_in),
    .o_erase_data_mem(o_erase_data_mem), .o_erase_prog_mem(o_erase_prog_mem));
  rcfg_pin_driver pin_u (.i_clk(I_CLK), .i_hold_low(hold_low),
    .i_pullup_en(o_pin_pullup_en), .o_pin(pin));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask
  task automatic wait_run();
    n = 0;
    while (o_core_reset !== 1'h0 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic cfg_wr(input logic [13:0] w);
    i_prog_mode = 1'h1;
    i_prog_addr = 14'h2007;
    i_prog_wdata = w;
    i_prog_wr = 1'h1;
    tick(1);
    i_prog_wr = 1'h0;
    chk(14'(o_cfg), 14'({w[11:8], ~w[7:6], w[5], ~w[4], w[3:0]}));
    chk(14'({o_erase_prog_mem, o_erase_data_mem}), 14'({!cur_w[6] && w[6], !cur_w[7] && w[7]}));
    chk(14'({o_pin_pullup_en, o_pin_digital_in}), 14'({w[5], !w[5]}));
    tick(1);
    chk(o_prog_rdata, w);
    cur_w = w;
    i_prog_mode = 1'h0;
  endtask
  task automatic pin_low(input int k);
    hold_low = 1'h1;
    tick(k);
    hold_low = 1'h0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(3);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    I_CLK = 1'h0;
    forever #5 I_CLK = !I_CLK;
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  // ==========================================================
  // Test sequence
  initial begin
    {I_RESET, i_power_on, hold_low, i_prog_mode, i_prog_wr, i_sleeping} = 6'h3F & 6'h30;
    {i_watchdog_timeout, i_interrupt, i_power_on_flag_set, i_clear_timeout_powerdown} = 4'h0;
    {i_enter_sleep, bor_in, bor_flag_set} = 3'h0;
    i_prog_addr = 14'h0000;
    i_prog_wdata = 14'h0000;
    cur_w = 14'h3FFF;
    tick(3);
    I_RESET = 1'h0;
    i_power_on = 1'h0;
    wait_run();
    chk(14'({o_core_reset, o_status.power_on_n}), 14'h0000);
    for (int i = 0; i < 8; i++) begin
      cfg_wr({2'h3, 3'(i), 3'(i), 3'(i), 3'(i)});
    end
    i_prog_addr = 14'h2007;
    tick(1);
    chk(o_prog_rdata, 14'h0000);
    i_prog_mode = 1'h1;
    i_prog_addr = 14'h2006;
    tick(1);
    chk(o_prog_rdata, 14'h0000);
    cfg_wr(14'h3FFC);
    wait_run();
    pin_low(50);
    tick(5);
    chk(14'(o_core_reset), 14'h0000);
    pin_low(260);
    chk(14'({o_core_reset, o_int_osc_stop}), 14'h0003);
    tick(10);
    wait_run();
    pulse(i_clear_timeout_powerdown);
    pulse(i_watchdog_timeout);
    chk(14'({o_status.timeout_status_flag, o_status.powerdown_status_flag}), 14'h0001);
    wait_run();
    pulse(i_clear_timeout_powerdown);
    pulse(i_enter_sleep);
    i_sleeping = 1'h1;
    i_interrupt = 1'h1;
    tick(1);
    chk(14'({o_wake, o_status.powerdown_status_flag}), 14'h0002);
    i_interrupt = 1'h0;
    pulse(i_watchdog_timeout);
    i_sleeping = 1'h0;
    chk(14'({o_status.timeout_status_flag, o_status.powerdown_status_flag}), 14'h0000);
    cfg_wr(14'h3FDC);
    wait_run();
    pin_low(260);
    chk(14'(o_core_reset), 14'h0000);
    cfg_wr(14'h3FE9);
    // Pin held low while ignored must filter back high under the pull-up
    wait_run();
    chk(14'(o_core_reset), 14'h0000);
    pulse(i_power_on_flag_set);
    chk(14'(o_status.power_on_n), 14'h0001);
    i_power_on = 1'h1;
    tick(10);
    i_power_on = 1'h0;
    wait_run();
    chk(14'(n >= 12 && n < 5000), 14'h0001);
    chk(14'(o_status.power_on_n), 14'h0000);
    // Brown-out in always-on mode, then recovery through both timers
    pulse(bor_flag_set);
    pulse(i_enter_sleep);
    chk(14'(o_status), 14'h0006);
    bor_in = 1'h1;
    tick(10);
    chk(14'({o_core_reset, o_status}), 14'h0013);
    bor_in = 1'h0;
    wait_run();
    chk(14'(n >= 12 && n < 5000), 14'h0001);
    tally_and_finish();
  end
endmodule
bind rcfg_reset_ctrl rcfg_reset_ctrl_props #(.PUT_TICKS(PUT_TICKS), .LFOSC_DIV(LFOSC_DIV))
  props_u (.I_CLK(I_CLK), .I_RESET(I_RESET), .i_power_on(i_power_on),
  .i_prog_mode(i_prog_mode), .i_prog_addr(i_prog_addr), .o_prog_rdata(o_prog_rdata),
  .i_sleeping(i_sleeping), .i_interrupt(i_interrupt), .o_cfg(o_cfg),
  .o_core_reset(o_core_reset), .o_power_on_reset(o_power_on_reset), .o_wake(o_wake),
  .o_int_osc_stop(o_int_osc_stop), .o_pin_pullup_en(o_pin_pullup_en),
  .o_pin_digital_in(o_pin_digital_in), .o_erase_data_mem(o_erase_data_mem),
  .o_erase_prog_mem(o_erase_prog_mem));
`default_nettype wire
